// File: hdl/ubs_top.sv
// boost and swap configuration bank with AHB-Lite slave, boost decode and DP/DM pin routing
//
// Implementation choice: the AHB-Lite interface to the registers.
`include "ubs_defines.svh"

// Overview of operation
// - upstream boost level comes from bits 1:0 of upstream byte; 00 means none.
// - codes 01, 10, 11 select low, medium, high boost of about 4, 8, 12 percent.
// - downstream port 3 boost level comes from bits 5:4 of downstream byte.
// - downstream port 2 boost level comes from bits 3:2 of downstream byte.
// - DP/DM roles can be swapped on upstream and downstream ports, each separately.
// - swap bit 0 routes D+ to DP pin and D- to DM pin.
// - swap bit 1 routes D+ to DM pin and D- to DP pin.
// - swap bits 3, 2, 0 control ports 3, 2, 0; bits 1 and 7:4 reserved.
module ubs_top #(
    parameter int SYNC_STAGES = 2
) (
    input wire logic hclk, // bus and core clock, 250 MHz
    input wire logic hresetn, // asynchronous reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready in
    output logic hreadyout, // slave ready out
    output logic hresp, // slave response
    output logic [31:0] hrdata, // read data
    input wire ubs_pkg::ubs_pair_t [2:0] core_tx, // core D+/D- drive per slot
    input wire logic [2:0] core_tx_oe, // core drives the pair per slot
    output ubs_pkg::ubs_pair_t [2:0] core_rx, // synchronised D+/D- seen at pads
    output ubs_pkg::ubs_pair_t [2:0] pad_o, // DP/DM pin output values
    output ubs_pkg::ubs_pair_t [2:0] pad_oe, // DP/DM pin output enables
    input wire ubs_pkg::ubs_pair_t [2:0] pad_i, // DP/DM pin input values
    output ubs_pkg::ubs_port_cfg_t [2:0] port_cfg // decoded boost and swap per slot
);
    import ubs_pkg::*;

    // elaboration check: the synchroniser needs two stages at least
    if (SYNC_STAGES < 2) begin : g_bad_sync
        $error("ubs_top: SYNC_STAGES must be 2 or more");
    end

    // the pad ports are three pairs wide, so the package must agree on the slot count
    if (UBS_NUM_SLOTS != 3) begin : g_bad_slots
        $error("ubs_top: UBS_NUM_SLOTS must be 3");
    end

    // configuration bytes
    logic [7:0] up_boost_r;
    logic [7:0] up_boost_nxt;
    logic [7:0] dn_boost_r;
    logic [7:0] dn_boost_nxt;
    logic [7:0] swap_r;
    logic [7:0] swap_nxt;

    // captured address phase
    logic wr_pend_r;
    logic [7:0] wr_idx_r;

    // bus answer flops
    logic hreadyout_r;
    logic hresp_r;
    logic [31:0] hrdata_r;
    logic [31:0] hrdata_nxt;

    // address phase decode
    wire addr_valid = hsel & htrans[`UBS_HTRANS_NONSEQ_BIT] & hready;
    wire addr_in_map = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
    wire [7:0] addr_idx = haddr[9:2];
    wire take_write = addr_valid & hwrite & (hsize == `UBS_HSIZE_WORD);
    wire take_read = addr_valid & ~hwrite;

    // data phase write strobes; only whole-word writes are taken
    wire wr_up = wr_pend_r && (wr_idx_r == `UBS_IDX_UP_BOOST);
    wire wr_dn = wr_pend_r && (wr_idx_r == `UBS_IDX_DN_BOOST);
    wire wr_sw = wr_pend_r && (wr_idx_r == `UBS_IDX_SWAP);

    // reserved masked
    // masking on write keeps reserved bits zero, so reads and decode never see them
    assign up_boost_nxt = wr_up ? (hwdata[7:0] & `UBS_UP_BOOST_MASK) : up_boost_r;
    assign dn_boost_nxt = wr_dn ? (hwdata[7:0] & `UBS_DN_BOOST_MASK) : dn_boost_r;
    assign swap_nxt = wr_sw ? (hwdata[7:0] & `UBS_SWAP_MASK) : swap_r;

    // register hits of the address phase; any other place reads zero
    wire hit_up = addr_in_map && (addr_idx == `UBS_IDX_UP_BOOST);
    wire hit_dn = addr_in_map && (addr_idx == `UBS_IDX_DN_BOOST);
    wire hit_sw = addr_in_map && (addr_idx == `UBS_IDX_SWAP);

    // read data selection; uses next values so a read right after a write sees it
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        if (!addr_in_map) begin
            rd_byte = 8'h00;
        end else if (hit_up) begin
            rd_byte = up_boost_nxt;
        end else if (hit_dn) begin
            rd_byte = dn_boost_nxt;
        end else if (hit_sw) begin
            rd_byte = swap_nxt;
        end
    end

    // upper lanes always read zero; reserved bits are already zero in the bytes
    assign hrdata_nxt = take_read ? {24'h000000, rd_byte} : 32'h00000000;

    // write pending: set by a taken whole-word write, held while the bus stalls
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
        end else if (hready) begin
            wr_pend_r <= take_write & addr_in_map;
        end
    end

    // write index: decoded only in the data phase, so the address path stays short
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_idx_r <= 8'h00;
        end else if (hready) begin
            wr_idx_r <= addr_idx;
        end
    end

    // upstream boost byte; resets to no boost
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            up_boost_r <= `UBS_UP_BOOST_RST;
        end else begin
            up_boost_r <= up_boost_nxt;
        end
    end

    // downstream boost byte; resets to no boost
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dn_boost_r <= `UBS_DN_BOOST_RST;
        end else begin
            dn_boost_r <= dn_boost_nxt;
        end
    end

    // swap byte; resets with every pair straight
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            swap_r <= `UBS_SWAP_RST;
        end else begin
            swap_r <= swap_nxt;
        end
    end

    // ready: zero wait states, so it never drops, not even in reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_r <= 1'b1;
        end else begin
            hreadyout_r <= 1'b1;
        end
    end

    // response: the bank refuses nothing loudly, so it is always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp_r <= `UBS_HRESP_OKAY;
        end else begin
            hresp_r <= `UBS_HRESP_OKAY;
        end
    end

    // read data: reloaded at every address edge, zero when no read is taken
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h00000000;
        end else if (hready) begin
            hrdata_r <= hrdata_nxt;
        end
    end

    // bus outputs straight from their flops
    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;
    assign hrdata = hrdata_r;

    // raw boost fields per slot
    // slot 0 is the upstream port, slots 1 and 2 are physical ports 2 and 3
    logic [1:0] boost_code [UBS_NUM_SLOTS];
    logic swap_bit [UBS_NUM_SLOTS];

    assign boost_code[0] = up_boost_r[`UBS_UP_BOOST_LSB +: 2];
    assign boost_code[1] = dn_boost_r[`UBS_P2_BOOST_LSB +: 2];
    assign boost_code[2] = dn_boost_r[`UBS_P3_BOOST_LSB +: 2];

    assign swap_bit[0] = swap_r[`UBS_SWAP_BIT_P0];
    assign swap_bit[1] = swap_r[`UBS_SWAP_BIT_P2];
    assign swap_bit[2] = swap_r[`UBS_SWAP_BIT_P3];

    // per-slot decode, routing and pad synchronisers
    for (genvar g = 0; g < UBS_NUM_SLOTS; g++) begin : g_slot
        ubs_boost_t level;
        logic [3:0] pct;
        ubs_port_cfg_t cfg_r;
        ubs_pair_t pad_o_r;
        ubs_pair_t pad_oe_r;
        ubs_pair_t rx_r;

        // routed pairs and the receive synchroniser
        ubs_pair_t route_o;
        ubs_pair_t route_rx;
        ubs_pair_t rx_last;
        ubs_pair_t sync_r [SYNC_STAGES];

        // level decode
        // the percent figure rides beside the level for the pad trim and for software
        assign level = ubs_boost_t'(boost_code[g]);
        always_comb begin
            pct = `UBS_PCT_NONE;
            case (level)
                UBS_BOOST_NONE: pct = `UBS_PCT_NONE;
                UBS_BOOST_LOW: pct = `UBS_PCT_LOW;
                UBS_BOOST_MED: pct = `UBS_PCT_MED;
                UBS_BOOST_HIGH: pct = `UBS_PCT_HIGH;
                default: pct = `UBS_PCT_NONE;
            endcase
        end

        // crossed routing
        // transmit side: a set swap bit puts the core's D+ on the DM pin
        assign route_o.dp = swap_bit[g] ? core_tx[g].dm : core_tx[g].dp;
        assign route_o.dm = swap_bit[g] ? core_tx[g].dp : core_tx[g].dm;

        // receive side crosses back the same way, so the core always sees D+ on dp
        assign rx_last = sync_r[SYNC_STAGES-1];
        assign route_rx.dp = swap_bit[g] ? rx_last.dm : rx_last.dp;
        assign route_rx.dm = swap_bit[g] ? rx_last.dp : rx_last.dm;

        // pad input synchroniser; only the next stage reads each stage
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                for (int s = 0; s < SYNC_STAGES; s++) begin
                    sync_r[s] <= '0;
                end
            end else begin
                sync_r[0] <= pad_i[g];
                for (int s = 1; s < SYNC_STAGES; s++) begin
                    sync_r[s] <= sync_r[s-1];
                end
            end
        end

        // decoded settings; routing follows a swap change one cycle later
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                cfg_r <= '{level: UBS_BOOST_NONE, pct: `UBS_PCT_NONE, swap: 1'b0};
            end else begin
                cfg_r <= '{level: level, pct: pct, swap: swap_bit[g]};
            end
        end

        // pin values after routing
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                pad_o_r <= '0;
            end else begin
                pad_o_r <= route_o;
            end
        end

        // pin enables; the enable travels with the pair, so both pins are driven together
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                pad_oe_r <= '0;
            end else begin
                pad_oe_r <= '{dp: core_tx_oe[g], dm: core_tx_oe[g]};
            end
        end

        // receive pair after routing, one flop past the synchroniser
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                rx_r <= '0;
            end else begin
                rx_r <= route_rx;
            end
        end

        // per-slot outputs straight from their flops
        assign port_cfg[g] = cfg_r;
        assign pad_o[g] = pad_o_r;
        assign pad_oe[g] = pad_oe_r;
        assign core_rx[g] = rx_r;
    end

endmodule

// File: hdl/ubs_defines.svh
// register indices, field positions, reset values and bus codes for the boost and swap bank
`ifndef UBS_DEFINES_SVH
`define UBS_DEFINES_SVH

// register indices; byte address is four times the index
`define UBS_IDX_UP_BOOST 8'hEF
`define UBS_IDX_DN_BOOST 8'hF0
`define UBS_IDX_SWAP 8'hF1

// field positions
`define UBS_UP_BOOST_LSB 0
`define UBS_P2_BOOST_LSB 2
`define UBS_P3_BOOST_LSB 4
`define UBS_SWAP_BIT_P0 0
`define UBS_SWAP_BIT_P2 2
`define UBS_SWAP_BIT_P3 3

// writable bits of each byte; all others are reserved
`define UBS_UP_BOOST_MASK 8'h03
`define UBS_DN_BOOST_MASK 8'h3C
`define UBS_SWAP_MASK 8'h0D

// reset values: no boost, no swap
`define UBS_UP_BOOST_RST 8'h00
`define UBS_DN_BOOST_RST 8'h00
`define UBS_SWAP_RST 8'h00

// boost in percent for each level
`define UBS_PCT_NONE 4'h0
`define UBS_PCT_LOW 4'h4
`define UBS_PCT_MED 4'h8
`define UBS_PCT_HIGH 4'hC

// AHB-Lite codes
`define UBS_HTRANS_NONSEQ_BIT 1
`define UBS_HSIZE_WORD 3'h2
`define UBS_HRESP_OKAY 1'h0

`endif

// File: hdl/ubs_pkg.sv
// types shared by the boost and swap configuration bank
package ubs_pkg;

    // four drive-strength levels, in field-code order
    typedef enum logic [1:0] {
        UBS_BOOST_NONE,
        UBS_BOOST_LOW,
        UBS_BOOST_MED,
        UBS_BOOST_HIGH
    } ubs_boost_t;

    // one differential pair, core side or pad side
    typedef struct packed {
        logic dp;
        logic dm;
    } ubs_pair_t;

    // decoded settings of one physical port
    typedef struct packed {
        ubs_boost_t level;
        logic [3:0] pct;
        logic swap;
    } ubs_port_cfg_t;

    // port slots of this bank: 0 upstream, 1 physical port 2, 2 physical port 3
    localparam int UBS_NUM_SLOTS = 3;

endpackage

// File: verification/ubs_props.sv
// concurrent checks on the boost and swap bank ports
`include "ubs_defines.svh"
module ubs_props (
    input wire logic hclk, // clock
    input wire logic hresetn, // reset
    input wire logic hsel, // select
    input wire logic [31:0] haddr, // address
    input wire logic [1:0] htrans, // type
    input wire logic hwrite, // write
    input wire logic [2:0] hsize, // size
    input wire logic [31:0] hwdata, // wdata
    input wire logic hready, // ready
    input wire logic [31:0] hrdata, // rdata
    input wire ubs_pkg::ubs_pair_t [2:0] core_tx, // core pairs
    input wire ubs_pkg::ubs_pair_t [2:0] pad_o, // pin pairs
    input wire ubs_pkg::ubs_port_cfg_t [2:0] port_cfg // settings
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [9:0] up_a = {`UBS_IDX_UP_BOOST, 2'h0};
    localparam logic [9:0] dn_a = {`UBS_IDX_DN_BOOST, 2'h0};
    localparam logic [9:0] sw_a = {`UBS_IDX_SWAP, 2'h0};
    logic [31:0] adr_r;
    logic wr_r, rd_r;
    logic [7:0] rsvd;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // remember the address phase; hsel stays low in reset, so no reset branch
    always_ff @(posedge hclk) begin
        if (hready) begin
            adr_r <= haddr;
            wr_r <= hsel && htrans[1] && hwrite && hsize == `UBS_HSIZE_WORD;
            rd_r <= hsel && htrans[1] && !hwrite;
        end
    end
    // reserved bits of the addressed byte; unmapped places read all zero
    assign rsvd = adr_r == up_a ? ~`UBS_UP_BOOST_MASK : adr_r == dn_a ? ~`UBS_DN_BOOST_MASK
        : adr_r == sw_a ? ~`UBS_SWAP_MASK : 8'hFF;
    // fields reach the settings two edges after the data phase
    a_up_level: assert property (wr_r && adr_r == up_a |-> ##2 port_cfg[0].level == 2'($past(hwdata, 2)))
        else $error("upstream level wrong");
    a_p3_level: assert property (wr_r && adr_r == dn_a |-> ##2 port_cfg[2].level == 2'($past(hwdata, 2) >> 4))
        else $error("port 3 level wrong");
    a_p2_level: assert property (wr_r && adr_r == dn_a |-> ##2 port_cfg[1].level == 2'($past(hwdata, 2) >> 2))
        else $error("port 2 level wrong");
    a_swap_bits: assert property (wr_r && adr_r == sw_a |-> ##2
        {port_cfg[2].swap, port_cfg[1].swap, 1'b0, port_cfg[0].swap} == 4'($past(hwdata, 2) & 32'hD))
        else $error("swap bits wrong");
    a_pct_code: assert property (port_cfg[2].pct == {port_cfg[2].level, 2'h0})
        else $error("boost percent wrong");
    // pins follow the core one edge later, exchanged when swapped
    a_route_plain: assert property ($past(hresetn) && !port_cfg[0].swap |-> pad_o[0] == $past(core_tx[0]))
        else $error("plain routing wrong");
    a_route_swap: assert property ($past(hresetn) && port_cfg[1].swap |->
        pad_o[1].dp == $past(core_tx[1].dm) && pad_o[1].dm == $past(core_tx[1].dp))
        else $error("swapped routing wrong");
    a_rsvd_zero: assert property (rd_r |-> hrdata[31:8] == 24'h0 && (hrdata[7:0] & rsvd) == 8'h0)
        else $error("reserved bits read nonzero");
    c_swap_write: cover property (wr_r && adr_r == sw_a);
    c_read_data: cover property (rd_r && hrdata != 32'h0);
    c_swap_high: cover property (port_cfg[2].swap && port_cfg[2].level == 2'h3);
endmodule
bind ubs_top ubs_props u_ubs_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .core_tx(core_tx),
    .pad_o(pad_o), .port_cfg(port_cfg));

// File: verification/ubs_top_tb_top.sv
// self-checking bench for the boost and swap configuration bank
`include "ubs_defines.svh"
module ubs_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rd_ph;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic [2:0] hsize, core_tx_oe;
    ubs_pkg::ubs_pair_t [2:0] core_tx, core_rx, pad_o, pad_oe, pad_i;
    ubs_pkg::ubs_port_cfg_t [2:0] port_cfg;
    logic [31:0] exp_q [$];
    logic [7:0] shd [3];
    int error_cnt, checks_done;
    localparam logic [9:0] adr [3] = '{{`UBS_IDX_UP_BOOST, 2'h0}, {`UBS_IDX_DN_BOOST, 2'h0}, {`UBS_IDX_SWAP, 2'h0}};
    localparam logic [7:0] msk [3] = '{`UBS_UP_BOOST_MASK, `UBS_DN_BOOST_MASK, `UBS_SWAP_MASK};
    localparam logic [7:0] swv [4] = '{8'hF2, 8'h01, 8'h0C, 8'h0D};
    assign hready = hreadyout;
    ubs_top u_ubs_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .core_tx(core_tx), .core_tx_oe(core_tx_oe), .core_rx(core_rx), .pad_o(pad_o), .pad_oe(pad_oe),
        .pad_i(pad_i), .port_cfg(port_cfg));
    // 250 MHz clock
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h0);
    endfunction
    // a set swap bit exchanges the two wires of its slot
    function automatic logic [5:0] route(input logic [5:0] v, input logic [2:0] s);
        return (v & ~{{2{s[2]}}, {2{s[1]}}, {2{s[0]}}}) | ({v[4], v[5], v[2], v[3], v[0], v[1]} & {{2{s[2]}}, {2{s[1]}}, {2{s[0]}}});
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // bounded wait for hready; a stuck slave ends the run
    task automatic wait_rdy();
        int n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (hreadyout !== 1'b1) begin
            error_cnt++;
            final_report();
        end
    endtask
    // one single word transfer; a read notes its expected data
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hsize <= `UBS_HSIZE_WORD;
        wait_rdy();
        if (!w) exp_q.push_back(d);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        chk(32'(hresp), 32'(`UBS_HRESP_OKAY));
    endtask
    // read data stands through the data phase and is taken at its closing rising edge
    always @(posedge hclk) begin
        if (rd_ph === 1'b1 && hready === 1'b1 && exp_q.size() > 0) begin
            chk(hrdata, exp_q.pop_front());
        end
        rd_ph <= hsel && htrans[1] && !hwrite && hready;
    end
    // random pin traffic after new settings; receive path has two sync flops plus routing
    task automatic pins(input logic [1:0] c, input logic [2:0] s);
        r = lfsr(r);
        core_tx <= r[5:0];
        core_tx_oe <= r[8:6];
        pad_i <= r[14:9];
        @(posedge hclk);
        @(negedge hclk);
        chk(32'(pad_o), 32'(route(r[5:0], s)));
        chk(32'(pad_oe), 32'({{2{r[8]}}, {2{r[7]}}, {2{r[6]}}}));
        chk(32'(port_cfg), {11'h0, c, c, 2'h0, s[2], c ^ 2'h1, c ^ 2'h1, 2'h0, s[1], c, c, 2'h0, s[0]});
        repeat (2) @(posedge hclk);
        @(negedge hclk);
        chk(32'(core_rx), 32'(route(r[14:9], s)));
        // hand back on a rising edge so the next transfer starts right after it
        @(posedge hclk);
    endtask
    initial begin
        {hresetn, hsel, hwrite, htrans, hsize, core_tx_oe} = '0;
        {haddr, hwdata, core_tx, pad_i} = '0;
        error_cnt = 0;
        checks_done = 0;
        shd = '{default: 8'h0};
        r = 32'h9B391A81;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // each register read back before each of its four random writes; its last write is not read back
        for (int k = 0; k < 12; k++) begin
            xfer(1'b0, 32'(adr[k % 3]), {24'h0, shd[k % 3]});
            r = lfsr(r);
            xfer(1'b1, 32'(adr[k % 3]), r);
            shd[k % 3] = r[7:0] & msk[k % 3];
        end
        xfer(1'b1, 32'(adr[2]) + 32'h4, 32'hFF);
        xfer(1'b0, 32'(adr[2]) + 32'h4, 32'h0);
        // every level on every slot, with swap patterns that include reserved bits
        for (int c = 0; c < 4; c++) begin
            xfer(1'b1, 32'(adr[0]), 32'(c));
            xfer(1'b1, 32'(adr[1]), 32'({c[1:0], c[1:0] ^ 2'h1, 2'h0}));
            xfer(1'b1, 32'(adr[2]), {24'h0, swv[c]});
            pins(c[1:0], {swv[c][3], swv[c][2], swv[c][0]});
        end
        // boost set back to no boost once done
        xfer(1'b1, 32'(adr[0]), 32'h0);
        xfer(1'b1, 32'(adr[1]), 32'h0);
        final_report();
    end
endmodule
